// ---- cid_debouncer.sv ----
// Contact input scanner, debouncer, event stamper and pass-aligned operand update
`timescale 1ns/1ps
module cid_debouncer #(
  parameter int N_IN = 16,
  parameter int PASS_CYCLES = 41667
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N_IN*cid_pkg::VOLT_W-1:0] input_volts,
  input wire logic [(N_IN/cid_pkg::GROUP_SIZE)*cid_pkg::VOLT_W-1:0] group_threshold,
  input wire logic [cid_pkg::DEB_W-1:0] debounce_interval,
  input wire logic [N_IN-1:0] event_enable,
  input wire logic [N_IN-1:0] input_fitted,
  input wire logic tracking_valid,
  input wire logic [31:0] tracked_pass_cycles,
  output logic [N_IN-1:0] input_closed_operand,
  output logic [N_IN-1:0] input_open_operand,
  output logic pass_start,
  output cid_pkg::cid_event_t event_out,
  output logic [cid_pkg::STAMP_W-1:0] time_us
);
  localparam int NG = N_IN / cid_pkg::GROUP_SIZE;

  typedef struct packed {
    logic [15:0] scan_cnt;
    logic [7:0] us_cnt;
    logic [cid_pkg::STAMP_W-1:0] time_us;
    logic [31:0] pass_cnt;
    logic pass_start;
    logic [N_IN-1:0] fitted;
    logic started;
    logic [N_IN-1:0] accepted;
    logic [N_IN-1:0] pending;
    logic [N_IN-1:0][cid_pkg::DEB_W-1:0] run_cnt;
    logic [N_IN-1:0][cid_pkg::STAMP_W-1:0] run_stamp;
    logic [N_IN-1:0] closed_op;
    logic [N_IN-1:0] open_op;
    logic [N_IN-1:0] ev_flag;
    cid_pkg::cid_event_t ev;
  } cid_state_t;

  cid_state_t q, d;
  logic [N_IN-1:0] raw;

  // Raw comparison, one threshold per group of four
  for (genvar i = 0; i < N_IN; i++)
  begin : g_cmp
    assign raw[i] = input_volts[i*cid_pkg::VOLT_W +: cid_pkg::VOLT_W] >=
      group_threshold[(i/cid_pkg::GROUP_SIZE)*cid_pkg::VOLT_W +: cid_pkg::VOLT_W];
  end

  always_comb
  begin
    logic scan;
    logic [31:0] plen;
    logic found;
    logic [N_IN-1:0] ev_set;
    scan = 1'b0;
    ev_set = '0;
    plen = 32'h0;
    found = 1'b0;
    d = q;
    d.pass_start = 1'b0;
    d.ev.valid = 1'b0;
    // Microsecond time base for stamps
    if (q.us_cnt == 8'(cid_pkg::US_CYCLES - 1))
    begin
      d.us_cnt = 8'h00;
      d.time_us = q.time_us + 32'h1;
    end
    else
    begin
      d.us_cnt = q.us_cnt + 8'h01;
    end
    // Common scan strobe for all inputs
    if (q.scan_cnt == 16'(cid_pkg::SCAN_CYCLES - 1))
    begin
      d.scan_cnt = 16'h0000;
      scan = 1'b1;
    end
    else
    begin
      d.scan_cnt = q.scan_cnt + 16'h0001;
    end
    // Pass length follows frequency tracking when it is valid
    plen = tracking_valid ? tracked_pass_cycles : 32'(PASS_CYCLES);
    if (plen < 32'h2)
    begin
      plen = 32'h2;
    end
    if (q.pass_cnt >= plen - 32'h1)
    begin
      d.pass_cnt = 32'h0;
      d.pass_start = 1'b1;
    end
    else
    begin
      d.pass_cnt = q.pass_cnt + 32'h1;
    end
    // Latch fitted inputs once after reset
    if (!q.started)
    begin
      d.started = 1'b1;
      d.fitted = input_fitted;
    end
    // Symmetric debounce per input
    if (scan && q.started)
    begin
      for (int i = 0; i < N_IN; i++)
      begin
        if (!q.fitted[i])
        begin
          d.pending[i] = 1'b0;
        end
        else if (raw[i] == q.accepted[i])
        begin
          d.pending[i] = 1'b0;
          d.run_cnt[i] = '0;
        end
        else if (!q.pending[i])
        begin
          d.pending[i] = 1'b1;
          d.run_cnt[i] = 8'h01;
          d.run_stamp[i] = q.time_us;
        end
        else
        begin
          d.run_cnt[i] = q.run_cnt[i] + 8'h01;
        end
        // Validate on sample interval+1 of the run (2.5 ms -> 6th), either direction;
        // comparing the old count keeps an interval of 255 from wrapping the counter
        if (q.fitted[i] && raw[i] != q.accepted[i] &&
          ((q.pending[i] ? q.run_cnt[i] : '0) >= debounce_interval))
        begin
          d.accepted[i] = raw[i];
          d.pending[i] = 1'b0;
          d.run_cnt[i] = '0;
          ev_set[i] = event_enable[i];
        end
      end
    end
    // One event record per cycle, lowest index first
    for (int i = 0; i < N_IN; i++)
    begin
      if (q.ev_flag[i] && !found)
      begin
        found = 1'b1;
        d.ev_flag[i] = 1'b0;
        d.ev.valid = 1'b1;
        d.ev.index = 8'(i);
        d.ev.closed = q.accepted[i];
        d.ev.stamp = q.run_stamp[i];
      end
    end
    // A fresh validation outranks the clear of a record sent this cycle
    d.ev_flag = d.ev_flag | ev_set;
    // Operands change only at pass start, so a pass sees one state
    if (q.pass_start)
    begin
      d.closed_op = q.accepted & q.fitted;
      d.open_op = ~q.accepted & q.fitted;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign input_closed_operand = q.closed_op;
  assign input_open_operand = q.open_op;
  assign pass_start = q.pass_start;
  assign event_out = q.ev;
  assign time_us = q.time_us;
endmodule

// ---- cid_pkg.sv ----
// Package of constants and types for the contact input debouncer
// Function
// - All inputs are sampled together on one strobe every 0.5 ms.
// - Raw sample compares input voltage with one threshold per group of four.
// - New state accepted after persisting the debounce interval; 2.5 ms means sixth sample.
// - Open-to-closed and closed-to-open use the same procedure and interval.
// - Operand reads 1 for closed contact; complementary operand shows open.
// - With logging enabled, every validated change produces an event record.
// - Event carries time of the first sample of the validating run.
// - Time stamps have 1 microsecond resolution, whatever the debounce interval.
// - Protection passes occur eight per power cycle, timed by frequency tracking.
// - Validated state copied to operand at start of the next protection pass.
// - Operand response equals debounce interval plus zero to one pass.
// - At startup, fitted inputs are found; absent inputs stay inactive.
package cid_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int SCAN_PERIOD_US = 500;
  localparam int SCAN_CYCLES = CLK_HZ / 1_000_000 * SCAN_PERIOD_US;
  localparam int STAMP_RES_US = 1;
  localparam int US_CYCLES = CLK_HZ / 1_000_000 * STAMP_RES_US;
  localparam int PASSES_PER_CYCLE = 8;
  localparam int GROUP_SIZE = 4;
  localparam int VOLT_W = 8;
  localparam int STAMP_W = 32;
  localparam int DEB_W = 8;
  localparam logic [DEB_W-1:0] DEB_RST = 8'h05;
  localparam logic [VOLT_W-1:0] THR_RST = 8'h11;

  // One logged change of one input
  typedef struct packed {
    logic valid;
    logic [7:0] index;
    logic closed;
    logic [STAMP_W-1:0] stamp;
  } cid_event_t;
endpackage

// ---- cid_debouncer_props.sv ----
// Port assertions for the contact input debouncer
`timescale 1ns/1ps
module cid_debouncer_props #(
  parameter int N_IN = 16,
  parameter int PASS_CYCLES = 41667
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [cid_pkg::DEB_W-1:0] debounce_interval,
  input wire logic [N_IN-1:0] event_enable,
  input wire logic [N_IN-1:0] input_fitted,
  input wire logic tracking_valid,
  input wire logic [31:0] tracked_pass_cycles,
  input wire logic [N_IN-1:0] input_closed_operand,
  input wire logic [N_IN-1:0] input_open_operand,
  input wire logic pass_start,
  input wire cid_pkg::cid_event_t event_out,
  input wire logic [cid_pkg::STAMP_W-1:0] time_us
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] since_pass;
  logic [31:0] trk_on;

  // Cycles since the last pass start, and how long tracking has held
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      since_pass <= 32'h0;
      trk_on <= 32'h0;
    end
    else
    begin
      since_pass <= pass_start ? 32'h1 : since_pass + 32'h1;
      trk_on <= tracking_valid ? trk_on + 32'h1 : 32'h0;
    end
  end
  // Operand pairs and pass timing
  a_ops_exclusive: assert property ((input_closed_operand & input_open_operand) == '0)
    else $error("closed and open operands both set");
  a_absent_quiet: assert property ((input_closed_operand & ~input_fitted) == '0)
    else $error("absent input reads closed");
  a_ops_at_pass: assert property (!$past(pass_start) |-> $stable(input_closed_operand))
    else $error("operand moved outside pass start");
  a_pass_pulse: assert property (pass_start |=> !pass_start)
    else $error("pass start longer than one cycle");
  a_pass_period: assert property (pass_start && !tracking_valid |->
    since_pass == 32'(PASS_CYCLES))
    else $error("pass spacing wrong");
  a_pass_tracked: assert property (pass_start && trk_on > since_pass |->
    since_pass == tracked_pass_cycles)
    else $error("tracked pass spacing wrong");
  // Events: enabled inputs only, stamped at the start of the run
  a_event_enabled: assert property (event_out.valid |-> event_enable[event_out.index])
    else $error("event from disabled input");
  a_stamp_age: assert property (event_out.valid |->
    time_us - event_out.stamp >= 500 * debounce_interval)
    else $error("stamp not from first sample");
  a_us_tick: assert property ($changed(time_us) |-> time_us == $past(time_us) + 1)
    else $error("time counter skipped");
endmodule

// ---- cid_contacts.sv ----
// Field contacts seen through a voltage code
`timescale 1ns/1ps
module cid_contacts #(
  parameter int N = 4
)(
  input wire logic [N-1:0] closed,
  input wire logic [N*8-1:0] noise,
  input wire logic [7:0] thr,
  output logic [N*8-1:0] volts
);
  // Noise wanders but never crosses the threshold, so only the contact decides;
  // closed levels saturate so a high threshold cannot wrap below itself
  always_comb
  begin
    logic [8:0] sum;
    sum = '0;
    for (int i = 0; i < N; i++)
    begin
      sum = {1'b0, thr} + {2'b00, noise[8*i+:7]};
      volts[8*i+:8] = closed[i] ? (sum[8] ? 8'hff : sum[7:0]) : noise[8*i+:8] % thr;
    end
  end
endmodule

// ---- test_cid_debouncer.sv ----
// Self-checking bench for the contact input debouncer
`timescale 1ns/1ps
module test_cid_debouncer;
  logic clk = 0;
  logic rst_n = 0;
  logic [3:0] closed = '0;
  logic [31:0] noise = '0;
  logic [7:0] interval = 8'h05;
  logic [7:0] thr = 8'h11;
  logic [31:0] thr_set = 32'ha6542111;
  logic [1:0] pick;
  logic [3:0] ev_en = 4'b1011;
  logic [3:0] fitted = 4'b0111;
  logic trk = 1'b0;
  logic [31:0] trk_len = 32'h0;
  logic [3:0] closed_op;
  logic [3:0] open_op;
  logic pass_start;
  cid_pkg::cid_event_t ev;
  logic [31:0] t_us;
  logic [31:0] volts;
  logic [16:0] exp_q[$];
  int seed = 32'hec1b7a83;
  int bad_count = 0;
  int num_checks = 0;
  cid_contacts i_field (.closed(closed), .noise(noise), .thr(thr), .volts(volts));
  cid_debouncer #(.N_IN(4), .PASS_CYCLES(100)) i_dut (.clk(clk), .rst_n(rst_n),
    .input_volts(volts), .group_threshold(thr), .debounce_interval(interval),
    .event_enable(ev_en), .input_fitted(fitted), .tracking_valid(trk),
    .tracked_pass_cycles(trk_len), .input_closed_operand(closed_op),
    .input_open_operand(open_op), .pass_start(pass_start), .event_out(ev), .time_us(t_us));
  initial
    forever #25 clk = ~clk;
  always @(posedge clk)
    noise <= $random(seed);
  task automatic chk_ev(input logic [16:0] n);
    logic [31:0] age;
    age = t_us - ev.stamp;
    num_checks++;
    if (ev.index !== n[16:9] || ev.closed !== n[8] || age !== 500 * n[7:0] && age !== 500 * n[7:0] + 1)
    begin
      bad_count++;
      $display("wrong value at %0t: event %h", $time, ev);
    end
  endtask
  task automatic chk_ops(input logic [3:0] c);
    num_checks++;
    if ({closed_op, open_op} !== {c, fitted & ~c})
    begin
      bad_count++;
      $display("wrong value at %0t: operands %h %h", $time, closed_op, open_op);
    end
  endtask
  task automatic results;
    bad_count += exp_q.size();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Oldest note meets each event as it appears
  always @(posedge clk)
    if (ev.valid === 1'b1)
      chk_ev(exp_q.size() > 0 ? exp_q.pop_front() : 17'h1ffff);
  // Close all, bounce one back, then open with a short interval
  initial
  begin
    repeat (20) @(posedge clk);
    pick = 2'($random(seed));
    thr <= thr_set[{pick, 3'b000} +: 8];
    rst_n <= 1;
    closed <= 4'hf;
    exp_q.push_back({8'h0, 1'b1, 8'h05});
    repeat (20000) @(posedge clk);
    closed <= 4'hd;
    repeat (40300) @(posedge clk);
    chk_ops(4'h5);
    interval <= 8'h01;
    trk <= 1'b1;
    trk_len <= 32'h50;
    closed <= 4'h0;
    exp_q.push_back({8'h0, 1'b0, 8'h01});
    repeat (20300) @(posedge clk);
    chk_ops(4'h0);
    results;
  end
  // Guard against a hang
  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    results;
  end
endmodule
bind cid_debouncer cid_debouncer_props #(.N_IN(N_IN), .PASS_CYCLES(PASS_CYCLES)) i_props (
  .clk(clk), .rst_n(rst_n), .debounce_interval(debounce_interval),
  .event_enable(event_enable), .input_fitted(input_fitted), .tracking_valid(tracking_valid),
  .tracked_pass_cycles(tracked_pass_cycles),
  .input_closed_operand(input_closed_operand), .input_open_operand(input_open_operand),
  .pass_start(pass_start), .event_out(event_out), .time_us(time_us));
